// [pkg/tcu_pkg.sv]
// shared constants and carrier types of the timer compare unit
package tcu_pkg;
  localparam logic [7:0] TCU_OFF_CONTROL = 8'h00;
  localparam logic [7:0] TCU_OFF_CMP_LOW = 8'h04;
  localparam logic [7:0] TCU_OFF_CMP_HIGH = 8'h08;
  localparam logic [7:0] TCU_OFF_STATUS = 8'h0C;
  localparam logic [7:0] TCU_OFF_MASK = 8'h10;
  localparam logic [7:0] TCU_OFF_ALT_PIN = 8'h14;
  localparam logic [7:0] TCU_OFF_TIMER = 8'h18;
  localparam logic [7:0] TCU_RST_CONTROL = 8'h00;
  localparam logic [7:0] TCU_RST_CMP = 8'h00;
  localparam logic [1:0] TCU_RST_MASK = 2'h0;
  localparam int TCU_MODE_LSB = 0;
  localparam int TCU_MODE_W = 4;
  localparam int TCU_ALT_BIT = 0;
  localparam int TCU_EVT_MATCH = 0;
  localparam int TCU_EVT_SPECIAL = 1;
  localparam int TCU_NUM_EVT = 2;
  localparam logic [3:0] TCU_MODE_TOGGLE = 4'h2;
  localparam logic [3:0] TCU_MODE_SET = 4'h8;
  localparam logic [3:0] TCU_MODE_CLEAR = 4'h9;
  localparam logic [3:0] TCU_MODE_SWI = 4'hA;
  localparam logic [3:0] TCU_MODE_SPECIAL = 4'hB;
  localparam int TCU_ADC_UNIT = 5;

  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } tcu_timer_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } tcu_pin_t;
endpackage : tcu_pkg

// [rtl/tcu_irq.sv]
// sticky event status with mask and level interrupt
`timescale 1ns/10ps
module tcu_irq #(
  parameter int N = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] evt,
  input wire logic [N-1:0] clr,
  input wire logic [N-1:0] mask_wdata,
  input wire logic mask_we,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  import tcu_pkg::*;

  logic [N-1:0] status_nxt;
  logic [N-1:0] mask_nxt;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      // a new event wins over a write-one-to-clear in the same cycle
      assign status_nxt[i] = evt[i] | (status[i] & ~clr[i]);
    end
  endgenerate

  // the interrupt follows a mask write in the same cycle as the mask itself
  assign mask_nxt = mask_we ? mask_wdata : mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
    end
    else
    begin
      status <= status_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask <= N'(TCU_RST_MASK);
    end
    else if (mask_we)
    begin
      mask <= mask_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_nxt & mask_nxt);
    end
  end
endmodule : tcu_irq

// [rtl/tcu_match.sv]
// equality detector between compare value and timer count
`timescale 1ns/10ps
module tcu_match #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] compare_value,
  input wire logic [WIDTH-1:0] timer_count,
  input wire logic run,
  output logic match,
  output logic match_rise
);
  import tcu_pkg::*;

  logic match_q_r;

  // equality is evaluated every cycle, so a changed compare value drops it at once
  assign match = run && (compare_value == timer_count);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_q_r <= 1'b0;
    end
    else
    begin
      match_q_r <= match;
    end
  end

  // one action per match, not one per cycle the count rests on the value
  assign match_rise = match && !match_q_r;
endmodule : tcu_match

// [rtl/tcu_top.sv]
// compare unit: apb registers, match actions, pin and special event logic
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
module tcu_top #(
  parameter int UNIT_ID = 1,
  parameter int CMP_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tcu_pkg::tcu_timer_t timer_in,
  input wire logic adc_enabled,
  input wire logic sleep,
  output logic special_event,
  output logic timer_reset,
  output logic adc_start,
  output logic unit_irq_flag,
  output logic irq,
  output tcu_pkg::tcu_pin_t pin_main,
  output tcu_pkg::tcu_pin_t pin_alt
);
  import tcu_pkg::*;

  logic [7:0] unit_control_r;
  logic [7:0] compare_value_low_r;
  logic [7:0] compare_value_high_r;
  logic alt_pin_select_r;
  logic out_latch_r;
  logic pending_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic timer_reset_r;
  logic adc_start_r;
  logic [3:0] compare_mode_field;
  logic [CMP_W-1:0] compare_value;
  logic match;
  logic match_rise;
  logic mode_pin;
  logic mode_any;
  logic mode_sev;
  logic access;
  logic wr_en;
  logic wr_lane0;
  logic mapped;
  logic [TCU_NUM_EVT-1:0] evt;
  logic [TCU_NUM_EVT-1:0] clr;
  logic [TCU_NUM_EVT-1:0] status;
  logic [TCU_NUM_EVT-1:0] mask;
  logic irq_w;
  logic [31:0] rd_nxt;

  assign compare_mode_field = unit_control_r[TCU_MODE_LSB +: TCU_MODE_W];
  assign compare_value = {compare_value_high_r, compare_value_low_r};

  // mode decode
  always_comb
  begin
    mode_pin = 1'b0;
    mode_any = 1'b0;
    mode_sev = 1'b0;
    case (compare_mode_field)
      TCU_MODE_TOGGLE, TCU_MODE_SET, TCU_MODE_CLEAR:
      begin
        mode_pin = 1'b1;
        mode_any = 1'b1;
      end
      TCU_MODE_SWI:
      begin
        mode_any = 1'b1;
      end
      TCU_MODE_SPECIAL:
      begin
        mode_any = 1'b1;
        mode_sev = 1'b1;
      end
      default:
      begin
        mode_any = 1'b0;
      end
    endcase
  end

  tcu_match #(
    .WIDTH(CMP_W)
  ) u_match (
    .pclk(pclk),
    .presetn(presetn),
    .compare_value(compare_value),
    .timer_count(timer_in.count),
    .run(mode_any && !sleep),
    .match(match),
    .match_rise(match_rise)
  );

  // apb slave: one wait state, answer on the second access cycle
  assign access = psel && penable;
  assign wr_en = access && pwrite && pready_r;
  assign wr_lane0 = wr_en && pstrb[0];

  always_comb
  begin
    mapped = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (paddr)
      TCU_OFF_CONTROL:
      begin
        rd_nxt[7:0] = unit_control_r;
      end
      TCU_OFF_CMP_LOW:
      begin
        rd_nxt[7:0] = compare_value_low_r;
      end
      TCU_OFF_CMP_HIGH:
      begin
        rd_nxt[7:0] = compare_value_high_r;
      end
      TCU_OFF_STATUS:
      begin
        rd_nxt[TCU_NUM_EVT-1:0] = status;
      end
      TCU_OFF_MASK:
      begin
        rd_nxt[TCU_NUM_EVT-1:0] = mask;
      end
      TCU_OFF_ALT_PIN:
      begin
        rd_nxt[TCU_ALT_BIT] = alt_pin_select_r;
      end
      TCU_OFF_TIMER:
      begin
        rd_nxt[CMP_W-1:0] = timer_in.count;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= access && !pready_r;
      pslverr_r <= access && !pready_r && !mapped;
      if (access && !pready_r && !pwrite)
      begin
        prdata_r <= rd_nxt;
      end
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_control_r <= TCU_RST_CONTROL;
      compare_value_low_r <= TCU_RST_CMP;
      compare_value_high_r <= TCU_RST_CMP;
      alt_pin_select_r <= 1'b0;
    end
    else if (wr_lane0)
    begin
      case (paddr)
        TCU_OFF_CONTROL:
        begin
          unit_control_r <= pwdata[7:0];
        end
        TCU_OFF_CMP_LOW:
        begin
          compare_value_low_r <= pwdata[7:0];
        end
        TCU_OFF_CMP_HIGH:
        begin
          compare_value_high_r <= pwdata[7:0];
        end
        TCU_OFF_ALT_PIN:
        begin
          alt_pin_select_r <= pwdata[TCU_ALT_BIT];
        end
        default:
        begin
          alt_pin_select_r <= alt_pin_select_r;
        end
      endcase
    end
  end

  // compare output latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_latch_r <= 1'b0;
    end
    else if (wr_lane0 && paddr == TCU_OFF_CONTROL && pwdata[7:0] == 8'h00)
    begin
      out_latch_r <= 1'b0;
    end
    else if (match_rise && mode_pin)
    begin
      case (compare_mode_field)
        TCU_MODE_TOGGLE:
        begin
          out_latch_r <= !out_latch_r;
        end
        TCU_MODE_SET:
        begin
          out_latch_r <= 1'b1;
        end
        default:
        begin
          out_latch_r <= 1'b0;
        end
      endcase
    end
  end

  // pin routing; drive only in pin modes, port keeps the pin otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_main <= '{out: 1'b0, oe_n: 1'b1};
      pin_alt <= '{out: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      pin_main.out <= out_latch_r;
      pin_alt.out <= out_latch_r;
      pin_main.oe_n <= !(mode_pin && !alt_pin_select_r);
      pin_alt.oe_n <= !(mode_pin && alt_pin_select_r);
    end
  end

  // special event output is the raw equality in trigger mode
  assign special_event = match && mode_sev;

  // timer reset waits for the timer tick and dies with the match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_r <= 1'b0;
    end
    else if (!special_event || timer_in.tick)
    begin
      pending_r <= 1'b0;
    end
    else if (match_rise)
    begin
      pending_r <= 1'b1;
    end
  end

  // the reset is a plain clear request, never an overflow indication
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_reset_r <= 1'b0;
      adc_start_r <= 1'b0;
    end
    else
    begin
      timer_reset_r <= pending_r && special_event && timer_in.tick;
      adc_start_r <= (UNIT_ID == TCU_ADC_UNIT) && adc_enabled && match_rise && mode_sev;
    end
  end

  assign evt[TCU_EVT_MATCH] = match_rise;
  assign evt[TCU_EVT_SPECIAL] = match_rise && mode_sev;
  assign clr = (wr_lane0 && paddr == TCU_OFF_STATUS) ? pwdata[TCU_NUM_EVT-1:0] : '0;

  tcu_irq #(
    .N(TCU_NUM_EVT)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .evt(evt),
    .clr(clr),
    .mask_wdata(pwdata[TCU_NUM_EVT-1:0]),
    .mask_we(wr_lane0 && paddr == TCU_OFF_MASK),
    .status(status),
    .mask(mask),
    .irq(irq_w)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign timer_reset = timer_reset_r;
  assign adc_start = adc_start_r;
  assign unit_irq_flag = status[TCU_EVT_MATCH];
  assign irq = irq_w;
endmodule : tcu_top

// [tb/tcu_timer_model.sv]
// timer count partner with a synchronous tick
`timescale 1ns/10ps
module tcu_timer_model #(
  parameter int DIV = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic timer_reset,
  output tcu_pkg::tcu_timer_t timer_out
);
  import tcu_pkg::*;
  int div_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      div_r <= 0;
      timer_out <= '0;
    end
    else
    begin
      div_r <= (div_r + 1) % DIV;
      timer_out.tick <= div_r == DIV - 1;
      if (timer_reset)
        timer_out.count <= '0;
      else if (timer_out.tick)
        timer_out.count <= timer_out.count + 16'h0001;
    end
endmodule : tcu_timer_model

// [tb/tcu_top_assertions.sv]
// port checks of the compare unit
`timescale 1ns/10ps
module tcu_top_assertions #(
  parameter int UNIT_ID = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire tcu_pkg::tcu_timer_t timer_in,
  input wire logic adc_enabled,
  input wire logic sleep,
  input wire logic special_event,
  input wire logic timer_reset,
  input wire logic adc_start,
  input wire logic unit_irq_flag,
  input wire tcu_pkg::tcu_pin_t pin_main,
  input wire tcu_pkg::tcu_pin_t pin_alt
);
  import tcu_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] ctl_r, lo_r, hi_r;
  logic [3:0] md;
  logic wr, m, ms, st;
  assign wr = psel && penable && pready && pwrite;
  assign md = ctl_r[3:0];
  // shadow of the match from observed register writes
  assign m = md inside {TCU_MODE_TOGGLE, TCU_MODE_SET, TCU_MODE_CLEAR, TCU_MODE_SWI, TCU_MODE_SPECIAL}
    && !sleep && {hi_r, lo_r} == timer_in.count;
  assign ms = md == TCU_MODE_SWI || md == TCU_MODE_SPECIAL;
  assign st = special_event && timer_in.tick;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctl_r <= TCU_RST_CONTROL;
      lo_r <= TCU_RST_CMP;
      hi_r <= TCU_RST_CMP;
    end
    else if (wr)
    begin
      if (paddr == TCU_OFF_CONTROL)
        ctl_r <= pwdata[7:0];
      if (paddr == TCU_OFF_CMP_LOW)
        lo_r <= pwdata[7:0];
      if (paddr == TCU_OFF_CMP_HIGH)
        hi_r <= pwdata[7:0];
    end
  a_special_eq: assert property (special_event == (m && md == TCU_MODE_SPECIAL))
    else $error("special event off");
  a_flag_rise: assert property ($rose(m) |=> unit_irq_flag)
    else $error("flag missing");
  a_set_high: assert property ($rose(m) && md == TCU_MODE_SET |-> ##2 (pin_main.out || pin_alt.out))
    else $error("set left pin low");
  a_reset_cause: assert property (timer_reset |-> $past(st))
    else $error("stray timer reset");
  a_adc_start: assert property ($rose(special_event) && adc_enabled |=> adc_start == (UNIT_ID == 5))
    else $error("conversion start wrong");
  a_adc_cause: assert property (adc_start |-> $past(special_event) && $past(adc_enabled))
    else $error("stray conversion start");
  a_pin_release: assert property (ms && $past(ms) && $past(ms, 2) |-> pin_main.oe_n && pin_alt.oe_n)
    else $error("pin driven");
  a_zero_latch: assert property (wr && paddr == TCU_OFF_CONTROL && pwdata[7:0] == 8'h00
    |-> ##[1:3] !pin_main.out && !pin_alt.out)
    else $error("latch not low");
  a_one_pin: assert property (pin_main.oe_n || pin_alt.oe_n)
    else $error("both pins driven");
  c_reset: cover property (timer_reset);
  c_adc: cover property (adc_start);
  c_swi: cover property ($rose(m) && md == TCU_MODE_SWI);
endmodule : tcu_top_assertions
bind tcu_top tcu_top_assertions #(.UNIT_ID(UNIT_ID)) tcu_top_assertions_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .timer_in, .adc_enabled, .sleep, .special_event, .timer_reset, .adc_start,
  .unit_irq_flag, .pin_main, .pin_alt);

// [tb/tcu_top_bench.sv]
// bench for the timer compare unit
`timescale 1ns/10ps
module tcu_top_bench;
  import tcu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic adc_enabled = 0, sleep = 0, pready, pslverr, special_event, timer_reset, adc_start, unit_irq_flag, irq;
  logic [7:0] paddr = '0;
  logic [15:0] t;
  logic [31:0] pwdata = '0, prdata, rd;
  tcu_timer_t timer_in;
  tcu_pin_t pin_main, pin_alt, p, q;
  int err_count = 0, check_count = 0, n_rst = 0, n_adc = 0, r0, i, n;
  always #4 pclk = ~pclk;
  always @(posedge pclk)
  begin
    n_rst <= n_rst + timer_reset;
    n_adc <= n_adc + adc_start;
  end
  tcu_timer_model tcu_timer_model_i (.pclk, .presetn, .timer_reset, .timer_out(timer_in));
  tcu_top #(.UNIT_ID(TCU_ADC_UNIT)) tcu_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .timer_in, .adc_enabled, .sleep, .special_event, .timer_reset,
    .adc_start, .unit_irq_flag, .irq, .pin_main, .pin_alt);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // bounded wait on flag, trigger or ready
  task wsig(input int s);
    for (n = 0; n < 99 && (s == 0 ? unit_irq_flag : s == 1 ? special_event : pready) !== 1'b1; n++)
      @(posedge pclk);
    if (n == 99)
    begin
      err_count++;
      results;
    end
  endtask : wsig
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    wsig(2);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // compare two timer steps ahead, mode written last
  task arm(input logic [3:0] c);
    t = timer_in.count + 16'h0002;
    apb(1'b1, TCU_OFF_CMP_LOW, {24'h0, t[7:0]});
    apb(1'b1, TCU_OFF_CMP_HIGH, {24'h0, t[15:8]});
    apb(1'b1, TCU_OFF_STATUS, 32'h3);
    apb(1'b1, TCU_OFF_CONTROL, {28'h0, c});
  endtask : arm
  task t_regs;
    apb(1'b0, TCU_OFF_CONTROL, '0);
    chk(rd, TCU_RST_CONTROL);
    apb(1'b0, TCU_OFF_MASK, '0);
    chk(rd, TCU_RST_MASK);
    apb(1'b1, TCU_OFF_CONTROL, 32'hA5);
    apb(1'b0, TCU_OFF_CONTROL, '0);
    chk(rd, 32'hA5);
    apb(1'b0, 8'h40, '0);
    chk(er, 1);
    chk(rd, 0);
    $display("regs done");
  endtask : t_regs
  task t_pins;
    logic [3:0] md [4] = '{TCU_MODE_TOGGLE, TCU_MODE_TOGGLE, TCU_MODE_CLEAR, TCU_MODE_SET};
    apb(1'b1, TCU_OFF_MASK, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, TCU_OFF_ALT_PIN, i % 2);
      arm(md[i]);
      wsig(0);
      chk(irq, 1);
      repeat (2) @(posedge pclk);
      p = i % 2 ? pin_alt : pin_main;
      q = i % 2 ? pin_main : pin_alt;
      chk({p.out, p.oe_n, q.oe_n}, {i == 0 || i == 3, 2'b01});
    end
    apb(1'b1, TCU_OFF_CONTROL, '0);
    @(posedge pclk);
    chk(pin_main.out | pin_alt.out, 0);
    $display("pins done");
  endtask : t_pins
  task t_special;
    adc_enabled <= 1'b1;
    apb(1'b1, TCU_OFF_MASK, 32'h3);
    r0 = n_adc;
    arm(TCU_MODE_SPECIAL);
    wsig(1);
    repeat (40) @(posedge pclk);
    chk(n_adc - r0, 1);
    chk(n_rst, 1);
    apb(1'b0, TCU_OFF_STATUS, '0);
    chk(rd, 3);
    chk(pin_main.oe_n & pin_alt.oe_n, 1);
    apb(1'b1, TCU_OFF_MASK, '0);
    chk(irq, 0);
    apb(1'b1, TCU_OFF_MASK, 32'h3);
    chk(irq, 1);
    apb(1'b1, TCU_OFF_STATUS, 32'h3);
    chk(irq, 0);
    adc_enabled <= 1'b0;
    arm(TCU_MODE_SPECIAL);
    wsig(1);
    apb(1'b1, TCU_OFF_CMP_HIGH, 32'h55);
    repeat (64) @(posedge pclk);
    chk(n_rst, 1);
    $display("special done");
  endtask : t_special
  task t_swi_sleep;
    sleep <= 1'b1;
    arm(TCU_MODE_SPECIAL);
    repeat (99) @(posedge pclk);
    apb(1'b0, TCU_OFF_STATUS, '0);
    chk(n_rst, 1);
    chk(rd, 0);
    sleep <= 1'b0;
    arm(TCU_MODE_SWI);
    wsig(0);
    repeat (2) @(posedge pclk);
    chk(pin_main.oe_n & pin_alt.oe_n, 1);
    apb(1'b0, TCU_OFF_STATUS, '0);
    chk(rd, 1);
    $display("swi and sleep done");
  endtask : t_swi_sleep
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_pins;
    t_special;
    t_swi_sleep;
    results;
  end
endmodule : tcu_top_bench
